//--- hdl/eatc_timer.sv
/*
  Auxiliary timer/counter and position counter of the encoder
  interface unit, with its AHB-Lite register slave and pin control.
  Assumes an external quadrature decoder supplies step, direction and
  index-event pulses synchronous to hclk; pins are sampled here.
*/
`timescale 1ns/1ps
`include "eatc_defines.svh"
module eatc_timer
  import eatc_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        phase_a_pin,
  input  wire logic        phase_b_pin,
  input  wire logic        index_pin,
  input  wire logic        qdec_step,
  input  wire logic        qdec_dir_up,
  input  wire logic        index_event,
  output logic             direction_status_pin,
  output logic             direction_status_oe,
  output logic             own_phase_a,
  output logic             own_phase_b,
  output logic             own_index,
  output logic             filter_bypass,
  output logic             irq_request
);

  eatc_state_t s;
  eatc_state_t next_s;

  // ==========================================================
  // pin sampling
  logic [2:0] pin_lvl;
  logic [2:0] pin_rise;
  logic [2:0] pin_fall;

  // external clock always goes through the synchroniser
  eatc_sync #(
    .W (3)
  ) u_sync (
    .hclk    (hclk),
    .hresetn (hresetn),
    .pin_in  ({index_pin, phase_b_pin, phase_a_pin}),
    .level   (pin_lvl),
    .rise    (pin_rise),
    .fall    (pin_fall)
  );

  // ==========================================================
  // mode decode and bus strobes
  logic is_timer;
  logic is_match;
  logic is_index;
  logic ap_take;
  logic wr_phase;
  logic wr_ctrl;
  logic wr_filt;
  logic wr_pos;
  logic wr_max;
  logic wr_irq;
  logic cnt_hold;
  logic tick;
  logic dir_up_t;
  logic gate_fall;

  assign is_timer = (s.mode == EATC_MODE_TIMER);
  assign is_match = (s.mode == EATC_MODE_MATCH_X2) || (s.mode == EATC_MODE_MATCH_X4);
  assign is_index = (s.mode == EATC_MODE_IDX_X2) || (s.mode == EATC_MODE_IDX_X4);

  assign ap_take  = hsel & htrans[1] & hready;
  assign wr_phase = (s.bus == EATC_BUS_WRITE);
  assign wr_ctrl  = wr_phase && (s.ap_addr == `EATC_ADDR_CTRL);
  assign wr_filt  = wr_phase && (s.ap_addr == `EATC_ADDR_FILT);
  assign wr_pos   = wr_phase && (s.ap_addr == `EATC_ADDR_POS);
  assign wr_max   = wr_phase && (s.ap_addr == `EATC_ADDR_MAX);
  assign wr_irq   = wr_phase && (s.ap_addr == `EATC_ADDR_IRQ);

  // timer clocking: gate and external clock together stop the count
  assign cnt_hold = s.clk_src & s.gate_en;
  assign tick     = cnt_hold  ? 1'b0 :
                    s.clk_src ? pin_rise[0] :
                    s.gate_en ? pin_lvl[0] :
                    1'b1;
  // direction from phase B or the software bit
  assign dir_up_t  = s.dir_src ? pin_lvl[1] : s.sw_dir;
  assign gate_fall = s.gate_en & ~s.clk_src & pin_fall[0];

  // ==========================================================
  // register read mux; unmapped offsets read zero
  function automatic logic [31:0] rd_word(input eatc_state_t st, input logic idx);
    logic [31:0] w;
    w = 32'h0000_0000;
    case (st.ap_addr)
      `EATC_ADDR_CTRL: begin
        w[`EATC_CTRL_DIR_SRC] = st.dir_src;
        w[`EATC_CTRL_CLK_SRC] = st.clk_src;
        w[`EATC_CTRL_POSRES]  = st.posres;
        w[`EATC_CTRL_GATE_EN] = st.gate_en;
        w[`EATC_CTRL_DIR_OUT] = st.dir_out_en;
        w[`EATC_CTRL_MODE_HI:`EATC_CTRL_MODE_LO] = st.mode;
        w[`EATC_CTRL_SW_DIR]  = st.sw_dir;
        w[`EATC_CTRL_INDEX]   = idx;
        w[`EATC_CTRL_CNT_ERR] = st.cnt_err;
      end
      `EATC_ADDR_FILT: w[`EATC_FILT_COUNT_ERROR_IRQ_DISABLE] = st.count_error_irq_disable;
      `EATC_ADDR_POS:  w[15:0] = st.pos;
      `EATC_ADDR_MAX:  w[15:0] = st.maxc;
      `EATC_ADDR_IRQ: begin
        w[`EATC_IRQ_FLAG] = st.irq_flag;
        w[`EATC_IRQ_EN]   = st.irq_en;
        w[`EATC_IRQ_PRIO_HI:`EATC_IRQ_PRIO_LO] = st.irq_prio;
      end
      default: w = 32'h0000_0000;
    endcase
    return w;
  endfunction

  // ==========================================================
  // counter, events, registers and bus in one next-state process
  logic [15:0] pos_nx;
  logic        ev;
  logic        err_set;

  always_comb begin
    next_s  = s;
    pos_nx  = s.pos;
    ev      = 1'b0;
    err_set = 1'b0;

    // counting only touches pos, so a mode change keeps it
    case (s.mode)
      EATC_MODE_TIMER: begin
        if (cnt_hold) begin
          ev = 1'b1;
        end else if (tick) begin
          if (s.pos == s.maxc) begin
            pos_nx = `EATC_POS_RST;
            ev     = 1'b1;
          end else if (dir_up_t) begin
            pos_nx = s.pos + 16'h0001;
          end else begin
            pos_nx = s.pos - 16'h0001;
          end
        end
        if (gate_fall) begin
          ev = 1'b1;
        end
      end
      EATC_MODE_MATCH_X2, EATC_MODE_MATCH_X4: begin
        if (qdec_step) begin
          if (qdec_dir_up) begin
            if (s.pos == s.maxc) begin
              pos_nx = `EATC_POS_RST;
              ev     = 1'b1;
            end else begin
              pos_nx = s.pos + 16'h0001;
            end
          end else if (s.pos == `EATC_POS_RST) begin
            pos_nx = s.maxc;
            ev     = 1'b1;
          end else begin
            pos_nx = s.pos - 16'h0001;
          end
        end
      end
      EATC_MODE_IDX_X2, EATC_MODE_IDX_X4: begin
        if (index_event) begin
          ev = 1'b1;
          if (s.posres) begin
            pos_nx = qdec_dir_up ? `EATC_POS_RST : s.maxc;
          end
        end else if (qdec_step) begin
          pos_nx = qdec_dir_up ? s.pos + 16'h0001 : s.pos - 16'h0001;
        end
        // boundary check; an error interrupts only while the error flag is clear
        if ((qdec_dir_up && (s.pos == 16'(s.maxc + 16'h0001))) ||
            (!qdec_dir_up && (s.pos == `EATC_CNT_ALL_ONES))) begin
          err_set = 1'b1;
        end
        if (err_set && !s.cnt_err && !s.count_error_irq_disable) begin
          ev = 1'b1;
        end
      end
      default: begin
        pos_nx = s.pos;  // off: no counting, no events
      end
    endcase

    // software write of the count wins over the counter
    next_s.pos = wr_pos ? hwdata[15:0] : pos_nx;
    if (wr_max) begin
      next_s.maxc = hwdata[15:0];
    end
    if (wr_filt) begin
      next_s.count_error_irq_disable = hwdata[`EATC_FILT_COUNT_ERROR_IRQ_DISABLE];
    end
    if (wr_ctrl) begin
      next_s.dir_src    = hwdata[`EATC_CTRL_DIR_SRC];
      next_s.clk_src    = hwdata[`EATC_CTRL_CLK_SRC];
      next_s.posres     = hwdata[`EATC_CTRL_POSRES];
      next_s.gate_en    = hwdata[`EATC_CTRL_GATE_EN];
      next_s.dir_out_en = hwdata[`EATC_CTRL_DIR_OUT];
      next_s.mode       = eatc_mode_t'(hwdata[`EATC_CTRL_MODE_HI:`EATC_CTRL_MODE_LO]);
      next_s.sw_dir     = hwdata[`EATC_CTRL_SW_DIR];
    end
    // error flag: write 0 clears, a new error wins
    next_s.cnt_err = err_set | (s.cnt_err & (~wr_ctrl | hwdata[`EATC_CTRL_CNT_ERR]));
    if (wr_irq) begin
      next_s.irq_en   = hwdata[`EATC_IRQ_EN];
      next_s.irq_prio = hwdata[`EATC_IRQ_PRIO_HI:`EATC_IRQ_PRIO_LO];
    end
    // sticky flag, write 1 clears, set wins
    next_s.irq_flag = ev | (s.irq_flag & ~(wr_irq & hwdata[`EATC_IRQ_FLAG]));
    // request needs enable and non-zero priority
    next_s.irq_req  = next_s.irq_flag & next_s.irq_en & (|next_s.irq_prio);

    // pin ownership follows the configuration
    next_s.filter_bypass = is_timer;
    next_s.own_a     = is_timer ? (s.gate_en | s.clk_src) : (is_match | is_index);
    next_s.own_b     = is_timer ? s.dir_src : (is_match | is_index);
    next_s.own_index = is_index;
    next_s.dir_oe    = (is_match | is_index) & s.dir_out_en;
    next_s.dir_pin   = next_s.dir_oe & qdec_dir_up;

    // bus: reads take one wait state so writes land first
    case (s.bus)
      EATC_BUS_READ: begin
        next_s.rdata = rd_word(s, pin_lvl[2]);
        next_s.ready = 1'b1;
      end
      EATC_BUS_WRITE, EATC_BUS_IDLE: begin
        next_s.ready = 1'b1;
      end
      default: begin
        next_s.ready = 1'b1;
      end
    endcase
    if (ap_take) begin
      next_s.bus     = hwrite ? EATC_BUS_WRITE : EATC_BUS_READ;
      next_s.ap_addr = haddr[7:0];
      next_s.ready   = hwrite;
    end else begin
      next_s.bus = EATC_BUS_IDLE;
    end
  end

  // ==========================================================
  // state register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s          <= '0;
      s.bus      <= EATC_BUS_IDLE;
      s.mode     <= EATC_MODE_OFF0;
      s.pos      <= `EATC_POS_RST;
      s.maxc     <= `EATC_MAX_RST;
      s.ready    <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // ==========================================================
  // outputs, all flops except hresp, which is tied low
  assign hrdata               = s.rdata;
  assign hreadyout            = s.ready;
  assign hresp                = 1'b0;
  assign direction_status_pin = s.dir_pin;
  assign direction_status_oe  = s.dir_oe;
  assign own_phase_a          = s.own_a;
  assign own_phase_b          = s.own_b;
  assign own_index            = s.own_index;
  assign filter_bypass        = s.filter_bypass;
  assign irq_request          = s.irq_req;

  // ==========================================================
  // checks
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  chk_filter_bypass: assert property (is_timer ##1 1'b1 |-> filter_bypass)
    else $error("filter not bypassed in timer mode");

  chk_period_wrap: assert property (is_timer && tick && !wr_pos && s.pos == s.maxc
      |=> s.pos == 16'h0000 && s.irq_flag)
    else $error("period match did not clear count and set flag");

  chk_count_up: assert property (is_timer && tick && dir_up_t && !wr_pos && s.pos != s.maxc
      |=> s.pos == 16'($past(s.pos) + 16'h0001))
    else $error("up count step wrong");

  chk_count_down: assert property (is_timer && tick && !dir_up_t && !wr_pos
      && s.pos != s.maxc |=> s.pos == 16'($past(s.pos) - 16'h0001))
    else $error("down count step wrong");

  chk_phase_b_dir: assert property (is_timer && s.dir_src |-> dir_up_t == pin_lvl[1])
    else $error("phase B not steering direction");

  chk_gated_hold: assert property (is_timer && cnt_hold && !wr_pos
      |=> $stable(s.pos) && s.irq_flag)
    else $error("count moved with gate and external clock");

  chk_flag_sticky: assert property (s.irq_flag && !(wr_irq && hwdata[0])
      |=> s.irq_flag [*1])
    else $error("interrupt flag lost without clear");

  chk_free_run: assert property (is_timer && !s.clk_src && !s.gate_en && !wr_pos
      && !wr_ctrl && s.pos != s.maxc && dir_up_t ##1 !wr_pos && s.pos != s.maxc
      |=> s.pos == 16'($past(s.pos, 2) + 16'h0002))
    else $error("internal clock not one step per cycle");

  chk_match_roll: assert property (is_match && qdec_step && qdec_dir_up && !wr_pos
      && s.pos == s.maxc |=> s.pos == 16'h0000 && s.irq_flag)
    else $error("rollover event missing");

  chk_index_irq: assert property (is_index && index_event |=> s.irq_flag)
    else $error("index event did not set flag");

  chk_count_error_irq_disable_mask: assert property (is_index && s.count_error_irq_disable && !index_event && !s.irq_flag
      && !(is_timer) |=> !s.irq_flag)
    else $error("count error raised interrupt while disabled");

  chk_off_quiet: assert property (!is_timer && !is_match && !is_index && !wr_pos
      && !wr_ctrl |=> $stable(s.pos) ##0 !own_phase_a && !own_phase_b && !own_index
      && !direction_status_oe)
    else $error("module off but active");

  chk_dir_pin: assert property (is_match && s.dir_out_en && !wr_ctrl
      |=> direction_status_oe && direction_status_pin == $past(qdec_dir_up))
    else $error("direction status pin not driven");

  cov_timer_wrap: cover property (is_timer && tick && s.pos == s.maxc);
  cov_gate_fall:  cover property (is_timer && gate_fall);
  cov_match_roll: cover property (is_match && qdec_step && s.pos == s.maxc);
  cov_read_back:  cover property (s.bus == EATC_BUS_READ ##1 hreadyout);

endmodule

//--- hdl/eatc_defines.svh
/*
  Register map, field positions and reset values of the auxiliary
  timer/counter of the encoder interface unit.
  Assumes a 32-bit AHB-Lite slave port with one word per register.
*/
`ifndef EATC_DEFINES_SVH
`define EATC_DEFINES_SVH

// ==========================================================
// register byte offsets
`define EATC_ADDR_CTRL      8'h00
`define EATC_ADDR_FILT      8'h04
`define EATC_ADDR_POS       8'h08
`define EATC_ADDR_MAX       8'h0c
`define EATC_ADDR_IRQ       8'h10

// ==========================================================
// module_control_reg fields
`define EATC_CTRL_DIR_SRC   0
`define EATC_CTRL_CLK_SRC   1
`define EATC_CTRL_POSRES    2
`define EATC_CTRL_GATE_EN   5
`define EATC_CTRL_DIR_OUT   6
`define EATC_CTRL_MODE_LO   8
`define EATC_CTRL_MODE_HI   10
`define EATC_CTRL_SW_DIR    11
`define EATC_CTRL_INDEX     12
`define EATC_CTRL_CNT_ERR   15
// filter_control_reg and interrupt register fields
`define EATC_FILT_COUNT_ERROR_IRQ_DISABLE      8
`define EATC_IRQ_FLAG       0
`define EATC_IRQ_EN         1
`define EATC_IRQ_PRIO_LO    2
`define EATC_IRQ_PRIO_HI    4

// ==========================================================
// reset values and the all-ones count
`define EATC_POS_RST        16'h0000
`define EATC_MAX_RST        16'hffff
`define EATC_CNT_ALL_ONES   16'hffff

`endif

//--- hdl/eatc_pkg.sv
/*
  Types shared by the auxiliary timer/counter design.
  Assumes the defines header is compiled alongside.
*/
package eatc_pkg;

  // ==========================================================
  // operating_mode_field encodings
  typedef enum logic [2:0] {
    EATC_MODE_OFF0     = 3'b000,
    EATC_MODE_TIMER    = 3'b001,
    EATC_MODE_OFF2     = 3'b010,
    EATC_MODE_OFF3     = 3'b011,
    EATC_MODE_IDX_X2   = 3'b100,
    EATC_MODE_MATCH_X2 = 3'b101,
    EATC_MODE_IDX_X4   = 3'b110,
    EATC_MODE_MATCH_X4 = 3'b111
  } eatc_mode_t;

  // bus data-phase state
  typedef enum logic [1:0] {
    EATC_BUS_IDLE  = 2'b00,
    EATC_BUS_WRITE = 2'b01,
    EATC_BUS_READ  = 2'b10
  } eatc_bus_t;

  typedef struct packed {
    eatc_bus_t   bus;
    logic [7:0]  ap_addr;
    eatc_mode_t  mode;
    logic        dir_src;
    logic        clk_src;
    logic        posres;
    logic        gate_en;
    logic        dir_out_en;
    logic        sw_dir;
    logic        cnt_err;
    logic        count_error_irq_disable;
    logic [15:0] pos;
    logic [15:0] maxc;
    logic        irq_flag;
    logic        irq_en;
    logic [2:0]  irq_prio;
    logic        irq_req;
    logic        filter_bypass;
    logic        own_a;
    logic        own_b;
    logic        own_index;
    logic        dir_pin;
    logic        dir_oe;
    logic [31:0] rdata;
    logic        ready;
  } eatc_state_t;

endpackage

//--- hdl/eatc_sync.sv
/*
  Two-stage synchroniser with a third stage for edge detection.
  Assumes inputs may change at any time relative to hclk.
*/
`timescale 1ns/1ps
module eatc_sync #(
  parameter int W = 3
) (
  input  wire logic         hclk,
  input  wire logic         hresetn,
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] level,
  output logic      [W-1:0] rise,
  output logic      [W-1:0] fall
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
  } eatc_sync_st_t;

  eatc_sync_st_t s;
  eatc_sync_st_t next_s;

  // ==========================================================
  // stage chain; only s2 reads s1
  always_comb begin
    next_s.s1 = pin_in;
    next_s.s2 = s.s1;
    next_s.s3 = s.s2;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // edges are seen two cycles after the pin moves
  assign level = s.s2;
  assign rise  = s.s2 & ~s.s3;
  assign fall  = ~s.s2 & s.s3;

endmodule

//--- testbench/eatc_enc_model.sv
/*
  Behavioural far side of the timer/counter: encoder phases, index,
  decoder step pulses and an external clock or gate on phase A.
  Assumes the bench calls its tasks just after a rising edge of hclk.
*/
`timescale 1ns/1ps
module eatc_enc_model (
  input  wire logic hclk,
  output logic      phase_a_pin,
  output logic      phase_b_pin,
  output logic      index_pin,
  output logic      qdec_step,
  output logic      qdec_dir_up,
  output logic      index_event
);
  // ==========================================================
  // pin drivers, all quiet at start
  initial begin
    {phase_a_pin, phase_b_pin, index_pin, qdec_step, qdec_dir_up, index_event} = '0;
  end

  // gate held high for exactly n edges, then a falling edge
  task automatic a_high(input int n);
    @(posedge hclk) phase_a_pin <= 1'b1;
    repeat (n) @(posedge hclk);
    phase_a_pin <= 1'b0;
  endtask

  // slow clock on phase A so the synchroniser never misses an edge
  task automatic a_clocks(input int n);
    repeat (n) begin
      @(posedge hclk) phase_a_pin <= 1'b1;
      repeat (2) @(posedge hclk);
      phase_a_pin <= 1'b0;
      repeat (2) @(posedge hclk);
    end
  endtask

  // direction level on phase B
  task automatic set_b(input logic v);
    @(posedge hclk) phase_b_pin <= v;
  endtask

  // decoder step pulses, one cycle each with a gap
  task automatic steps(input int n, input logic up);
    @(posedge hclk) qdec_dir_up <= up;
    repeat (n) begin
      @(posedge hclk) qdec_step <= 1'b1;
      @(posedge hclk) qdec_step <= 1'b0;
    end
  endtask

  // index level with a one-cycle detect pulse inside it
  task automatic index_pulse();
    @(posedge hclk) begin
      index_pin   <= 1'b1;
      index_event <= 1'b1;
    end
    @(posedge hclk) index_event <= 1'b0;
    @(posedge hclk) index_pin <= 1'b0;
  endtask
endmodule

//--- testbench/test_encoder_aux_timer_counter.sv
/*
  Self-checking bench: AHB-Lite master tasks, encoder model, directed
  scenarios for timer, encoder and off modes.
  Assumes the design sources and the encoder model are compiled first.
*/
`timescale 1ns/1ps
`include "eatc_defines.svh"
module test_encoder_aux_timer_counter
  import eatc_pkg::*;
;
  // ==========================================================
  // signals and constants
  logic        hclk = 1'b0;
  logic        hresetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        pa, pb, pi, stp, dup, iev;
  logic        dir_pin, dir_oe, own_a, own_b, own_i, fbyp, irq;
  logic [31:0] rdv;
  int          num_errors = 0;
  int          samples_checked = 0;
  int          cycles = 0;
  localparam logic [31:0] DSRC = 32'h1 << `EATC_CTRL_DIR_SRC;
  localparam logic [31:0] CSRC = 32'h1 << `EATC_CTRL_CLK_SRC;
  localparam logic [31:0] POSR = 32'h1 << `EATC_CTRL_POSRES;
  localparam logic [31:0] GATE = 32'h1 << `EATC_CTRL_GATE_EN;
  localparam logic [31:0] DOUT = 32'h1 << `EATC_CTRL_DIR_OUT;
  localparam logic [31:0] SWUP = 32'h1 << `EATC_CTRL_SW_DIR;
  localparam logic [31:0] CERR = 32'h1 << `EATC_CTRL_CNT_ERR;
  localparam logic [31:0] FLG  = 32'h1 << `EATC_IRQ_FLAG;
  localparam logic [31:0] ION  = (32'h1 << `EATC_IRQ_EN) | (32'h5 << `EATC_IRQ_PRIO_LO);
  eatc_mode_t  rm [2] = '{EATC_MODE_MATCH_X2, EATC_MODE_MATCH_X4};
  eatc_mode_t  im [2] = '{EATC_MODE_IDX_X2, EATC_MODE_IDX_X4};
  eatc_mode_t  om [3] = '{EATC_MODE_OFF0, EATC_MODE_OFF2, EATC_MODE_OFF3};

  always #2.5 hclk = ~hclk;

  // ==========================================================
  // design and far side
  eatc_timer dut_u (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .phase_a_pin(pa),
    .phase_b_pin(pb), .index_pin(pi), .qdec_step(stp), .qdec_dir_up(dup),
    .index_event(iev), .direction_status_pin(dir_pin), .direction_status_oe(dir_oe),
    .own_phase_a(own_a), .own_phase_b(own_b), .own_index(own_i),
    .filter_bypass(fbyp), .irq_request(irq)
  );
  eatc_enc_model model_u (
    .hclk(hclk), .phase_a_pin(pa), .phase_b_pin(pb), .index_pin(pi),
    .qdec_step(stp), .qdec_dir_up(dup), .index_event(iev)
  );

  // ==========================================================
  // bus, compare and report tasks
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    hsize  <= 3'h2;
    haddr  <= {24'h0, a};
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hsel   <= 1'b0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rdv = hrdata;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string m);
    bus(1'b0, a, 32'h0);
    chk(rdv, exp, m);
  endtask

  // pin ownership and status outputs as one word
  task automatic pins(input logic [5:0] e, input string m);
    chk({26'h0, own_a, own_b, own_i, dir_oe, fbyp, irq}, {26'h0, e}, m);
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge hclk);
  endtask

  function automatic logic [31:0] cw(input eatc_mode_t md, input logic [31:0] b);
    return ({29'h0, md} << `EATC_CTRL_MODE_LO) | b;
  endfunction

  task automatic print_verdict();
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // hang guard, far above the few hundred cycles the run needs
  always @(posedge hclk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      print_verdict();
    end
  end

  // ==========================================================
  // scenarios
  initial begin
    hresetn <= 1'b0;
    {hsel, haddr, htrans, hwrite, hsize, hwdata} <= '0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    pins(6'b000000, "reset pins");
    chk({31'h0, hresp}, 32'h0, "okay");
    rdchk(`EATC_ADDR_CTRL, 32'h0, "ctrl rst");
    rdchk(`EATC_ADDR_POS, 32'h0, "pos rst");
    rdchk(`EATC_ADDR_MAX, 32'hffff, "max rst");
    bus(1'b1, 8'h14, 32'hffff_ffff);
    rdchk(8'h14, 32'h0, "unmapped");
    // gated accumulation counts only while the gate is high
    bus(1'b1, `EATC_ADDR_MAX, 32'hff);
    bus(1'b1, `EATC_ADDR_CTRL, cw(EATC_MODE_TIMER, GATE | SWUP));
    idle(2);
    pins(6'b100010, "gate pins");
    rdchk(`EATC_ADDR_POS, 32'h0, "gate low");
    model_u.a_high(5);
    idle(4);
    rdchk(`EATC_ADDR_POS, 32'h5, "gate up");
    rdchk(`EATC_ADDR_IRQ, FLG, "gate fall");
    bus(1'b1, `EATC_ADDR_IRQ, FLG);
    rdchk(`EATC_ADDR_IRQ, 32'h0, "flag clr");
    bus(1'b1, `EATC_ADDR_CTRL, cw(EATC_MODE_TIMER, GATE));
    model_u.a_high(3);
    idle(4);
    rdchk(`EATC_ADDR_POS, 32'h2, "gate down");
    // down count: period taken downward from all ones
    bus(1'b1, `EATC_ADDR_IRQ, ION | FLG);
    bus(1'b1, `EATC_ADDR_POS, 32'h0);
    bus(1'b1, `EATC_ADDR_MAX, 32'hfffe);
    bus(1'b1, `EATC_ADDR_CTRL, cw(EATC_MODE_TIMER, CSRC));
    idle(2);
    pins(6'b100010, "ext pins");
    model_u.a_clocks(4);
    idle(4);
    rdchk(`EATC_ADDR_POS, 32'hffff, "down match");
    rdchk(`EATC_ADDR_IRQ, ION | FLG, "match flag");
    chk({31'h0, irq}, 32'h1, "irq out");
    // phase B picks the direction
    bus(1'b1, `EATC_ADDR_IRQ, ION | FLG);
    bus(1'b1, `EATC_ADDR_POS, 32'h0);
    bus(1'b1, `EATC_ADDR_MAX, 32'h2);
    bus(1'b1, `EATC_ADDR_CTRL, cw(EATC_MODE_TIMER, CSRC | DSRC));
    model_u.set_b(1'b1);
    idle(2);
    pins(6'b110010, "b pins");
    model_u.a_clocks(4);
    idle(4);
    rdchk(`EATC_ADDR_POS, 32'h1, "up wrap");
    rdchk(`EATC_ADDR_IRQ, ION | FLG, "up flag");
    model_u.set_b(1'b0);
    model_u.a_clocks(2);
    idle(4);
    rdchk(`EATC_ADDR_POS, 32'hffff, "b down");
    // gate and external clock together: hold, still interrupt
    bus(1'b1, `EATC_ADDR_CTRL, cw(EATC_MODE_TIMER, CSRC | GATE));
    bus(1'b1, `EATC_ADDR_IRQ, ION | FLG);
    model_u.a_clocks(3);
    idle(4);
    rdchk(`EATC_ADDR_POS, 32'hffff, "both hold");
    rdchk(`EATC_ADDR_IRQ, ION | FLG, "both irq");
    // off modes keep the count and stay quiet
    foreach (om[i]) begin
      bus(1'b1, `EATC_ADDR_CTRL, cw(om[i], GATE | DSRC));
      bus(1'b1, `EATC_ADDR_IRQ, ION | FLG);
      idle(2);
      pins(6'b000000, "off pins");
      model_u.a_clocks(1);
      idle(4);
      rdchk(`EATC_ADDR_POS, 32'hffff, "off keep");
      rdchk(`EATC_ADDR_IRQ, ION, "off quiet");
    end
    // free running internal clock stays within the period
    bus(1'b1, `EATC_ADDR_POS, 32'h0);
    bus(1'b1, `EATC_ADDR_MAX, 32'h3);
    bus(1'b1, `EATC_ADDR_CTRL, cw(EATC_MODE_TIMER, SWUP));
    idle(20);
    bus(1'b1, `EATC_ADDR_CTRL, cw(EATC_MODE_OFF0, 32'h0));
    bus(1'b0, `EATC_ADDR_POS, 32'h0);
    // 22 internal ticks from zero over a period of four leave two
    chk(rdv, 32'h2, "free run");
    rdchk(`EATC_ADDR_IRQ, ION | FLG, "free flag");
    // reset-on-match encoder modes: rollover and underflow
    foreach (rm[i]) begin
      bus(1'b1, `EATC_ADDR_POS, 32'h0);
      bus(1'b1, `EATC_ADDR_CTRL, cw(rm[i], DOUT));
      bus(1'b1, `EATC_ADDR_IRQ, ION | FLG);
      idle(2);
      pins(6'b110100, "match pins");
      model_u.steps(4, 1'b1);
      idle(3);
      rdchk(`EATC_ADDR_POS, 32'h0, "roll");
      rdchk(`EATC_ADDR_IRQ, ION | FLG, "roll irq");
      chk({31'h0, dir_pin}, 32'h1, "dir up");
      bus(1'b1, `EATC_ADDR_IRQ, ION | FLG);
      model_u.steps(1, 1'b0);
      idle(3);
      rdchk(`EATC_ADDR_POS, 32'h3, "under");
      rdchk(`EATC_ADDR_IRQ, ION | FLG, "under irq");
      chk({31'h0, dir_pin}, 32'h0, "dir down");
    end
    // reset-on-index modes: index reset and interrupt
    foreach (im[i]) begin
      bus(1'b1, `EATC_ADDR_MAX, 32'h9);
      bus(1'b1, `EATC_ADDR_POS, 32'h5);
      bus(1'b1, `EATC_ADDR_CTRL, cw(im[i], POSR));
      model_u.steps(1, 1'b1);
      bus(1'b1, `EATC_ADDR_IRQ, ION | FLG);
      idle(2);
      pins(6'b111000, "index pins");
      model_u.index_pulse();
      idle(3);
      rdchk(`EATC_ADDR_POS, 32'h0, "index rst");
      rdchk(`EATC_ADDR_IRQ, ION | FLG, "index irq");
    end
    // count error: masked, then unmasked after clearing the status
    bus(1'b1, `EATC_ADDR_FILT, 32'h1 << `EATC_FILT_COUNT_ERROR_IRQ_DISABLE);
    bus(1'b1, `EATC_ADDR_MAX, 32'h1);
    bus(1'b1, `EATC_ADDR_POS, 32'h0);
    bus(1'b1, `EATC_ADDR_IRQ, ION | FLG);
    model_u.steps(2, 1'b1);
    idle(3);
    bus(1'b0, `EATC_ADDR_CTRL, 32'h0);
    chk(rdv & CERR, CERR, "cnt err");
    rdchk(`EATC_ADDR_IRQ, ION, "err masked");
    bus(1'b1, `EATC_ADDR_POS, 32'h0);
    bus(1'b1, `EATC_ADDR_CTRL, cw(EATC_MODE_IDX_X4, POSR));
    bus(1'b1, `EATC_ADDR_FILT, 32'h0);
    model_u.steps(2, 1'b1);
    idle(3);
    rdchk(`EATC_ADDR_IRQ, ION | FLG, "err irq");
    print_verdict();
  end
endmodule
